// File: hw/lf_transponder_command_decoder.sv
// Downlink command frame decoder with link-clock byte assembly and crossing
module lf_transponder_command_decoder (
	input  wire logic              clk,            // System clock, 100 MHz
	input  wire logic              sys_rst,        // Synchronous reset, active high
	input  wire logic              link_clk,       // Downlink bit clock
	input  wire logic              link_bit_valid, // One received bit, link domain
	input  wire logic              link_bit,       // Received bit value
	input  wire logic              link_frame_end, // Frame finished, link domain
	input  wire logic [7:0]        stored_sel,     // Stored selective address
	input  wire logic [63:0]       page_protect,   // Protection bit per page
	output logic                   cmd_valid,      // Accepted command pulse
	output lf_cmd_pkg::op_t        cmd_op,         // Decoded operation
	output logic [5:0]             cmd_page,       // Target page
	output logic [47:0]            cmd_data,       // Write data, first byte low
	output logic                   cmd_respond,    // Command expects an answer
	output logic                   cmd_drop,       // Frame discarded pulse
	output logic                   charge_mode     // Battery charge in progress
);
	typedef enum {ST_COLLECT, ST_EVAL} st_t;

	function automatic lf_cmd_pkg::dec_t decode(input logic [7:0] a, input logic sel_en);
		logic [5:0]       pg;
		logic [1:0]       c;
		logic             idp;
		logic             usr;
		lf_cmd_pkg::dec_t d;
		pg    = a[7:2];
		c     = a[1:0];
		idp   = (pg >= lf_cmd_pkg::PG_ID_LO) && (pg <= lf_cmd_pkg::PG_ID_HI);
		usr   = ((pg >= lf_cmd_pkg::PG_USR_A_LO) && (pg <= lf_cmd_pkg::PG_USR_A_HI)) ||
		        ((pg >= lf_cmd_pkg::PG_USR_B_LO) && (pg <= lf_cmd_pkg::PG_USR_B_HI));
		d.op    = lf_cmd_pkg::OP_NONE;
		d.sel   = 1'b0;
		d.ndata = 4'h0;
		d.len   = lf_cmd_pkg::LEN_ADDR;
		unique case (c)
			lf_cmd_pkg::CMD_READ: begin
				if (pg == lf_cmd_pkg::PG_BATT_CHK) d.op = lf_cmd_pkg::OP_BATT_CHECK;
				else if (pg == lf_cmd_pkg::PG_BATT_CHG) d.op = lf_cmd_pkg::OP_BATT_CHARGE;
				else if (idp || usr) d.op = lf_cmd_pkg::OP_READ;
			end
			lf_cmd_pkg::CMD_PROG: begin
				if (pg == lf_cmd_pkg::PG_HOST) begin
					d.op    = lf_cmd_pkg::OP_HOST_RELAY;
					d.ndata = lf_cmd_pkg::HOST_LEN;
				end else if (idp || usr) begin
					d.op    = lf_cmd_pkg::OP_PROGRAM;
					d.sel   = sel_en;
					d.ndata = lf_cmd_pkg::PROG_LEN;
				end
			end
			lf_cmd_pkg::CMD_LOCK: begin
				if (idp || usr) begin
					d.op  = lf_cmd_pkg::OP_LOCK;
					d.sel = sel_en;
				end
			end
			lf_cmd_pkg::CMD_SELRD: begin
				if (idp) begin
					d.op  = lf_cmd_pkg::OP_SEL_READ;
					d.sel = 1'b1;
				end else if (usr) begin
					d.op  = lf_cmd_pkg::OP_PROTECT;
					d.sel = sel_en;
				end
			end
		endcase
		if (c != lf_cmd_pkg::CMD_READ)
			d.len = lf_cmd_pkg::LEN_ADDR + {3'h0, d.sel} + d.ndata + lf_cmd_pkg::LEN_FCB;
		return d;
	endfunction : decode

	// Link domain: reset sync, bit shifter and request side of the handshake
	logic       lrst_s1_ff, lrst_s2_ff;
	logic       ack_s1_ff, ack_s2_ff;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] hold_ff, nxt_hold;
	logic [2:0] bitcnt_ff, nxt_bitcnt;
	logic       byte_pend_ff, nxt_byte_pend;
	logic       end_pend_ff, nxt_end_pend;
	logic       req_ff, nxt_req;
	logic [8:0] word_ff, nxt_word;
	logic       taken_ff;

	always_ff @(posedge link_clk) begin
		lrst_s1_ff <= sys_rst;
		lrst_s2_ff <= lrst_s1_ff;
		ack_s1_ff  <= taken_ff;
		ack_s2_ff  <= ack_s1_ff;
	end

	always_comb begin
		nxt_shift     = shift_ff;
		nxt_hold      = hold_ff;
		nxt_bitcnt    = bitcnt_ff;
		nxt_byte_pend = byte_pend_ff;
		nxt_end_pend  = end_pend_ff;
		nxt_req       = req_ff;
		nxt_word      = word_ff;
		// Bytes leave before the end marker so the marker closes the frame
		if (req_ff == ack_s2_ff) begin
			if (byte_pend_ff) begin
				nxt_word      = {1'b0, hold_ff};
				nxt_req       = ~req_ff;
				nxt_byte_pend = 1'b0;
			end else if (end_pend_ff) begin
				nxt_word      = {1'b1, 8'h00};
				nxt_req       = ~req_ff;
				nxt_end_pend  = 1'b0;
			end
		end
		if (link_bit_valid) begin
			// First bit lands in the top position of the first byte
			nxt_shift  = {shift_ff[6:0], link_bit};
			nxt_bitcnt = bitcnt_ff + 3'h1;
			if (bitcnt_ff == lf_cmd_pkg::BIT_LAST) begin
				nxt_hold      = {shift_ff[6:0], link_bit};
				nxt_byte_pend = 1'b1;
			end
		end
		if (link_frame_end) begin
			nxt_end_pend = 1'b1;
			nxt_bitcnt   = 3'h0;
		end
	end

	always_ff @(posedge link_clk) begin
		if (lrst_s2_ff) begin
			shift_ff     <= 8'h00;
			hold_ff      <= 8'h00;
			bitcnt_ff    <= 3'h0;
			byte_pend_ff <= 1'b0;
			end_pend_ff  <= 1'b0;
			req_ff       <= 1'b0;
			word_ff      <= 9'h000;
		end else begin
			shift_ff     <= nxt_shift;
			hold_ff      <= nxt_hold;
			bitcnt_ff    <= nxt_bitcnt;
			byte_pend_ff <= nxt_byte_pend;
			end_pend_ff  <= nxt_end_pend;
			req_ff       <= nxt_req;
			word_ff      <= nxt_word;
		end
	end

	// System domain: acknowledge side and two-entry buffer
	logic       req_s1_ff, req_s2_ff;
	logic       nxt_taken;
	logic [8:0] fifo_ff [lf_cmd_pkg::FIFO_DEPTH];
	logic [8:0] nxt_fifo [lf_cmd_pkg::FIFO_DEPTH];
	logic       wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [1:0] fcnt_ff, nxt_fcnt;
	logic       push, pop, fifo_ready, fifo_valid, dec_ready;

	assign fifo_ready = (fcnt_ff != 2'(lf_cmd_pkg::FIFO_DEPTH));
	assign fifo_valid = (fcnt_ff != 2'h0);
	assign push       = (req_s2_ff != taken_ff) && fifo_ready;
	assign pop        = fifo_valid && dec_ready;

	always_comb begin
		nxt_taken = taken_ff;
		nxt_fifo  = fifo_ff;
		nxt_wp    = wp_ff;
		nxt_rp    = rp_ff;
		nxt_fcnt  = fcnt_ff;
		if (push) begin
			// Word is held steady by the link side until the toggle returns
			nxt_fifo[wp_ff] = word_ff;
			nxt_wp          = ~wp_ff;
			nxt_taken       = ~taken_ff;
		end
		if (pop)
			nxt_rp = ~rp_ff;
		nxt_fcnt = fcnt_ff + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			req_s1_ff  <= 1'b0;
			req_s2_ff  <= 1'b0;
			taken_ff   <= 1'b0;
			fifo_ff[0] <= 9'h000;
			fifo_ff[1] <= 9'h000;
			wp_ff      <= 1'b0;
			rp_ff      <= 1'b0;
			fcnt_ff    <= 2'h0;
		end else begin
			req_s1_ff  <= req_ff;
			req_s2_ff  <= req_s1_ff;
			taken_ff   <= nxt_taken;
			fifo_ff    <= nxt_fifo;
			wp_ff      <= nxt_wp;
			rp_ff      <= nxt_rp;
			fcnt_ff    <= nxt_fcnt;
		end
	end

	// Frame collection and evaluation
	st_t              st_ff, nxt_st;
	logic [7:0]       frame_ff [lf_cmd_pkg::FRAME_MAX];
	logic [7:0]       nxt_frame [lf_cmd_pkg::FRAME_MAX];
	logic [3:0]       idx_ff, nxt_idx;
	logic [7:0]       fcb_ff, nxt_fcb;
	logic             nxt_valid, nxt_respond, nxt_drop, charge_ff, nxt_charge;
	lf_cmd_pkg::op_t  op_ff, nxt_op;
	logic [5:0]       page_ff, nxt_page;
	logic [47:0]      data_ff, nxt_data;
	logic             valid_ff, respond_ff, drop_ff;
	lf_cmd_pkg::dec_t dec;
	logic             sel_en, ok;
	logic [8:0]       head;
	logic [7:0]       raw;
	logic [3:0]       base;

	assign dec_ready = (st_ff == ST_COLLECT);
	assign head      = fifo_ff[rp_ff];
	assign sel_en    = (stored_sel != lf_cmd_pkg::SEL_OFF);
	assign dec       = decode(frame_ff[0], sel_en);

	always_comb begin
		nxt_st      = st_ff;
		nxt_frame   = frame_ff;
		nxt_idx     = idx_ff;
		nxt_fcb     = fcb_ff;
		nxt_valid   = 1'b0;
		nxt_drop    = 1'b0;
		nxt_respond = respond_ff;
		nxt_op      = op_ff;
		nxt_page    = page_ff;
		nxt_data    = data_ff;
		nxt_charge  = charge_ff;
		ok          = 1'b0;
		raw         = head[7:0];
		base        = 4'h1 + {3'h0, dec.sel};
		unique case (st_ff)
			ST_COLLECT: begin
				if (pop && head[lf_cmd_pkg::END_BIT]) begin
					if (idx_ff != 4'h0)
						nxt_st = ST_EVAL;
				end else if (pop) begin
					if (idx_ff == 4'h0)
						// First byte arrives command-first; restore page-high order
						nxt_frame[0] = {raw[5:0], raw[7:6]};
					else if (idx_ff < 4'(lf_cmd_pkg::FRAME_MAX))
						nxt_frame[idx_ff] = raw;
					if (idx_ff != lf_cmd_pkg::IDX_MAX)
						nxt_idx = idx_ff + 4'h1;
					nxt_fcb = fcb_ff ^ raw;
				end
			end
			ST_EVAL: begin
				ok = (dec.op != lf_cmd_pkg::OP_NONE) && (idx_ff == dec.len);
				if ((dec.len != lf_cmd_pkg::LEN_ADDR) && (fcb_ff != lf_cmd_pkg::FCB_INIT))
					ok = 1'b0;
				if (dec.sel && sel_en && (frame_ff[1] != stored_sel))
					ok = 1'b0;
				if ((dec.op == lf_cmd_pkg::OP_PROGRAM) && page_protect[frame_ff[0][7:2]])
					ok = 1'b0;
				if (ok) begin
					nxt_valid   = 1'b1;
					nxt_op      = dec.op;
					nxt_page    = frame_ff[0][7:2];
					nxt_respond = (dec.op != lf_cmd_pkg::OP_BATT_CHARGE);
					nxt_charge  = (dec.op == lf_cmd_pkg::OP_BATT_CHARGE);
					nxt_data    = 48'h0;
					for (int i = 0; i < lf_cmd_pkg::DATA_MAX; i++) begin
						if (4'(i) < dec.ndata)
							nxt_data[i*8 +: 8] = frame_ff[4'(base + 4'(i))];
					end
				end else begin
					nxt_drop = 1'b1;
				end
				nxt_idx = 4'h0;
				nxt_fcb = lf_cmd_pkg::FCB_INIT;
				nxt_st  = ST_COLLECT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff      <= ST_COLLECT;
			for (int i = 0; i < lf_cmd_pkg::FRAME_MAX; i++)
				frame_ff[i] <= 8'h00;
			idx_ff     <= 4'h0;
			fcb_ff     <= lf_cmd_pkg::FCB_INIT;
			valid_ff   <= 1'b0;
			drop_ff    <= 1'b0;
			respond_ff <= 1'b0;
			op_ff      <= lf_cmd_pkg::OP_NONE;
			page_ff    <= 6'h00;
			data_ff    <= 48'h0;
			charge_ff  <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			frame_ff   <= nxt_frame;
			idx_ff     <= nxt_idx;
			fcb_ff     <= nxt_fcb;
			valid_ff   <= nxt_valid;
			drop_ff    <= nxt_drop;
			respond_ff <= nxt_respond;
			op_ff      <= nxt_op;
			page_ff    <= nxt_page;
			data_ff    <= nxt_data;
			charge_ff  <= nxt_charge;
		end
	end

	assign cmd_valid   = valid_ff;
	assign cmd_op      = op_ff;
	assign cmd_page    = page_ff;
	assign cmd_data    = data_ff;
	assign cmd_respond = respond_ff;
	assign cmd_drop    = drop_ff;
	assign charge_mode = charge_ff;
endmodule : lf_transponder_command_decoder

// File: shared/lf_cmd_pkg.sv
// Constants and types shared by the downlink command decoder
package lf_cmd_pkg;
	localparam int          BYTE_W      = 8;
	localparam int          WORD_W      = 9;
	localparam int          END_BIT     = 8;
	localparam int          FIFO_DEPTH  = 2;
	localparam int          FRAME_MAX   = 9;
	localparam int          DATA_MAX    = 6;
	localparam int          SYNC_DEPTH  = 2;

	localparam logic [2:0]  BIT_LAST    = 3'h7;

	// Command field, low two bits of the write-address byte
	localparam logic [1:0]  CMD_READ    = 2'h0;
	localparam logic [1:0]  CMD_PROG    = 2'h1;
	localparam logic [1:0]  CMD_LOCK    = 2'h2;
	localparam logic [1:0]  CMD_SELRD   = 2'h3;

	// Page field, upper six bits of the write-address byte
	localparam logic [5:0]  PG_ID_LO    = 6'h01;
	localparam logic [5:0]  PG_ID_HI    = 6'h03;
	localparam logic [5:0]  PG_USR_A_LO = 6'h08;
	localparam logic [5:0]  PG_USR_A_HI = 6'h0f;
	localparam logic [5:0]  PG_BATT_CHK = 6'h13;
	localparam logic [5:0]  PG_BATT_CHG = 6'h1a;
	localparam logic [5:0]  PG_HOST     = 6'h1f;
	localparam logic [5:0]  PG_USR_B_LO = 6'h28;
	localparam logic [5:0]  PG_USR_B_HI = 6'h37;

	localparam logic [7:0]  SEL_OFF     = 8'hff;
	localparam logic [7:0]  FCB_INIT    = 8'h00;
	localparam logic [3:0]  PROG_LEN    = 4'h5;
	localparam logic [3:0]  HOST_LEN    = 4'h6;
	localparam logic [3:0]  LEN_ADDR    = 4'h1;
	localparam logic [3:0]  LEN_FCB     = 4'h1;
	localparam logic [3:0]  IDX_MAX     = 4'hf;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_READ,
		OP_SEL_READ,
		OP_PROGRAM,
		OP_LOCK,
		OP_PROTECT,
		OP_BATT_CHECK,
		OP_BATT_CHARGE,
		OP_HOST_RELAY
	} op_t;

	typedef struct packed {
		op_t        op;
		logic       sel;
		logic [3:0] ndata;
		logic [3:0] len;
	} dec_t;
endpackage : lf_cmd_pkg

// File: tb/lf_cmd_checker_assertions.sv
// Port assertions for the downlink command decoder
module lf_cmd_checker (
	input wire logic		clk,		// Clock
	input wire logic		sys_rst,	// Reset
	input wire logic [63:0]		page_protect,	// Protect bits
	input wire logic		cmd_valid,	// Accept pulse
	input wire lf_cmd_pkg::op_t	cmd_op,		// Operation
	input wire logic [5:0]		cmd_page,	// Page
	input wire logic [47:0]		cmd_data,	// Write data
	input wire logic		cmd_respond,	// Answer flag
	input wire logic		cmd_drop,	// Drop pulse
	input wire logic		charge_mode	// Charging
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_ONE_RESULT: assert property (!(cmd_valid && cmd_drop))
		else $error("valid and drop together");
	AST_RESULT_GAP: assert property ((cmd_valid || cmd_drop) |=> !(cmd_valid || cmd_drop))
		else $error("results too close");
	AST_OUT_HOLD: assert property (!cmd_valid |-> $stable({cmd_op, cmd_page, cmd_data}))
		else $error("outputs moved without accept");
	AST_CHARGE: assert property (cmd_valid && cmd_op == lf_cmd_pkg::OP_BATT_CHARGE
		|-> charge_mode && !cmd_respond)
		else $error("charge accept wrong");
	AST_CHARGE_END: assert property (cmd_valid && cmd_op != lf_cmd_pkg::OP_BATT_CHARGE
		|-> !charge_mode && cmd_respond)
		else $error("charge not ended");
	AST_CHARGE_HOLD: assert property ($changed(charge_mode) |-> cmd_valid)
		else $error("charge moved alone");
	AST_NO_PROT_PROG: assert property (cmd_valid && cmd_op == lf_cmd_pkg::OP_PROGRAM
		|-> !page_protect[cmd_page] && cmd_data[47:40] == 8'h00)
		else $error("program on protected page");
	AST_HOST_PAGE: assert property (cmd_valid && cmd_op == lf_cmd_pkg::OP_HOST_RELAY
		|-> cmd_page == 6'h1f)
		else $error("relay page wrong");
	AST_SELRD_PAGE: assert property (cmd_valid && cmd_op == lf_cmd_pkg::OP_SEL_READ
		|-> cmd_page inside {[6'h01:6'h03]})
		else $error("selective read page wrong");
	AST_PROT_PAGE: assert property (cmd_valid && cmd_op == lf_cmd_pkg::OP_PROTECT
		|-> cmd_page inside {[6'h08:6'h0f], [6'h28:6'h37]})
		else $error("protect page wrong");
	cover property (cmd_valid && charge_mode);
	cover property (cmd_drop);
	cover property (cmd_valid && cmd_op == lf_cmd_pkg::OP_HOST_RELAY);
endmodule : lf_cmd_checker

bind lf_transponder_command_decoder lf_cmd_checker u_lf_cmd_checker (
	.clk(clk), .sys_rst(sys_rst), .page_protect(page_protect), .cmd_valid(cmd_valid),
	.cmd_op(cmd_op), .cmd_page(cmd_page), .cmd_data(cmd_data), .cmd_respond(cmd_respond),
	.cmd_drop(cmd_drop), .charge_mode(charge_mode)
);

// File: tb/lf_reader_model.sv
// Base station model sending downlink frames on the link clock
module lf_reader_model (
	input  wire logic	link_clk,	// Link clock
	output logic		link_bit_valid,	// Bit strobe
	output logic		link_bit,	// Bit value
	output logic		link_frame_end	// Frame end pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		link_bit_valid = 1'b0;
		link_bit = 1'b0;
		link_frame_end = 1'b0;
	end
	// Bytes go MSB first so the command field leads
	task automatic send(input logic [7:0] fr[$], input int gap);
		foreach (fr[i]) begin
			for (int b = 7; b >= 0; b--) begin
				@(posedge link_clk);
				link_bit_valid <= 1'b1;
				link_bit <= fr[i][b];
			end
			repeat (gap) begin
				@(posedge link_clk);
				link_bit_valid <= 1'b0;
				link_bit <= ~link_bit;
			end
		end
		@(posedge link_clk);
		link_bit_valid <= 1'b0;
		link_bit <= ~link_bit;
		link_frame_end <= 1'b1;
		// Idle bit line toggles for 8 link clocks, then holds its last value
		repeat (8) begin
			@(posedge link_clk);
			link_frame_end <= 1'b0;
			link_bit <= ~link_bit;
		end
	endtask : send
endmodule : lf_reader_model

// File: tb/lf_transponder_command_decoder_tb_top.sv
// Self-checking bench for the downlink command decoder
module lf_transponder_command_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic			clk = 1'b0;
	logic			link_clk = 1'b0;
	logic			sys_rst = 1'b1;
	logic			link_bit_valid, link_bit, link_frame_end;
	logic [7:0]		stored_sel = 8'hff;
	logic [63:0]		page_protect = '0;
	logic [63:0]		pp = '0;
	logic			cmd_valid, cmd_respond, cmd_drop, charge_mode, r_v, chg;
	lf_cmd_pkg::op_t	cmd_op;
	logic [5:0]		cmd_page;
	logic [47:0]		cmd_data;
	int			n_fail = 0, checks = 0, n_res = 0;
	byte unsigned		tbl[8] = '{8'ha0, 8'h4c, 8'h68, 8'h07, 8'h21, 8'h7d, 8'hde, 8'h3f};
	always #5 clk = ~clk;
	initial begin
		#3;
		forever #24 link_clk = ~link_clk;
	end
	lf_transponder_command_decoder u_lf_transponder_command_decoder (
		.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .link_bit_valid(link_bit_valid),
		.link_bit(link_bit), .link_frame_end(link_frame_end), .stored_sel(stored_sel),
		.page_protect(page_protect), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_page(cmd_page), .cmd_data(cmd_data), .cmd_respond(cmd_respond),
		.cmd_drop(cmd_drop), .charge_mode(charge_mode));
	lf_reader_model u_lf_reader_model (.link_clk(link_clk), .link_bit_valid(link_bit_valid),
		.link_bit(link_bit), .link_frame_end(link_frame_end));
	always @(posedge clk) begin
		if (cmd_valid === 1'b1 || cmd_drop === 1'b1) begin
			r_v <= cmd_valid;
			n_res <= n_res + 1;
		end
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : check
	function automatic lf_cmd_pkg::op_t exp_op(input logic [1:0] c, input logic [5:0] p);
		logic id, usr;
		id = p inside {[6'h01:6'h03]};
		usr = p inside {[6'h08:6'h0f], [6'h28:6'h37]};
		if (c == 2'h0 && (id || usr)) return lf_cmd_pkg::OP_READ;
		if (c == 2'h0 && p == 6'h13) return lf_cmd_pkg::OP_BATT_CHECK;
		if (c == 2'h0 && p == 6'h1a) return lf_cmd_pkg::OP_BATT_CHARGE;
		if (c == 2'h1 && (id || usr)) return lf_cmd_pkg::OP_PROGRAM;
		if (c == 2'h1 && p == 6'h1f) return lf_cmd_pkg::OP_HOST_RELAY;
		if (c == 2'h2 && (id || usr)) return lf_cmd_pkg::OP_LOCK;
		if (c == 2'h3 && id) return lf_cmd_pkg::OP_SEL_READ;
		if (c == 2'h3 && usr) return lf_cmd_pkg::OP_PROTECT;
		return lf_cmd_pkg::OP_NONE;
	endfunction : exp_op
	task automatic run(input logic [1:0] c, input logic [5:0] p, input bit son, sbad, bad,
			ext, input int gap);
		lf_cmd_pkg::op_t op;
		logic [7:0] fr[$];
		logic [7:0] x, ss;
		logic [47:0] d;
		bit sp, hf, ok;
		int n, n0;
		op = exp_op(c, p);
		ss = son ? 8'($urandom_range(0, 254)) : 8'hff;
		@(posedge clk);
		stored_sel <= ss;
		page_protect <= pp;
		sp = op == lf_cmd_pkg::OP_SEL_READ || (ss != 8'hff && op inside
			{lf_cmd_pkg::OP_PROGRAM, lf_cmd_pkg::OP_LOCK, lf_cmd_pkg::OP_PROTECT});
		hf = !(op inside {lf_cmd_pkg::OP_READ, lf_cmd_pkg::OP_BATT_CHECK,
			lf_cmd_pkg::OP_BATT_CHARGE});
		n = op == lf_cmd_pkg::OP_PROGRAM ? 5 : op == lf_cmd_pkg::OP_HOST_RELAY ? 6 : 0;
		fr.push_back({c, p}); // Command bits lead the page bits
		if (sp) fr.push_back(sbad ? ~ss : ss);
		d = '0;
		for (int k = 0; k < n; k++) begin
			x = 8'($urandom());
			d[k*8 +: 8] = x;
			fr.push_back(x);
		end
		if (ext) fr.push_back(8'h3c);
		x = 8'h00;
		foreach (fr[i]) x ^= fr[i];
		if (hf) fr.push_back(bad ? ~x : x);
		ok = op != lf_cmd_pkg::OP_NONE && !(bad && hf) && !ext && !(sp && ss != 8'hff && sbad)
			&& !(op == lf_cmd_pkg::OP_PROGRAM && pp[p]);
		if (ok) chg = op == lf_cmd_pkg::OP_BATT_CHARGE;
		n0 = n_res;
		u_lf_reader_model.send(fr, gap);
		for (int k = 0; k < 100 && n_res == n0; k++) @(posedge clk);
		check(64'(n_res - n0), 64'h1);
		check(r_v, ok);
		check(charge_mode, chg);
		if (ok) begin
			check(cmd_op, op);
			check(cmd_page, p);
			check(cmd_data, d);
			check(cmd_respond, op != lf_cmd_pkg::OP_BATT_CHARGE);
		end
	endtask : run
	task automatic wrap_up();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#800us;
		n_fail++;
		wrap_up();
	end
	initial begin
		chg = 1'b0;
		void'($urandom(32'h01f0b113));
		repeat (24) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge link_clk);
		foreach (tbl[i]) run(tbl[i][1:0], tbl[i][7:2], i[0], 0, 0, 0, 0);
		pp = 64'h0000_0000_0000_0100;
		run(2'h1, 6'h08, 0, 0, 0, 0, 1);
		run(2'h0, 6'h1a, 0, 0, 0, 0, 0); // Field held up while charging
		run(2'h2, 6'h09, 0, 0, 1, 0, 0);
		run(2'h1, 6'h28, 1, 1, 0, 0, 2);
		run(2'h1, 6'h1f, 1, 0, 0, 1, 3);
		run(2'h0, 6'h13, 0, 0, 0, 0, 0);
		repeat (90) begin
			pp = {$urandom(), $urandom()} & 64'h00ff_ff00_0000_ff00;
			run(2'($urandom()), 6'($urandom()), 1'($urandom()), $urandom_range(0, 3) == 0,
				$urandom_range(0, 7) == 0, $urandom_range(0, 7) == 0, $urandom_range(0, 3));
		end
		wrap_up();
	end
endmodule : lf_transponder_command_decoder_tb_top
